// ==== logic/scr_regs.sv ====
/*
 * System control register bank of the accelerometer: rate/mode, power
 * scheme and wake/interrupt-pin registers, auto-sleep timer and soft reset.
 * Assumes the serial interface decodes the bus into one-cycle read/write
 * strobes on the core clock and honours o_comm_rst while it is high.
 * The 4g clamp, the self-test shift and the fast-read pointer skip live in
 * the sensing path and the serial interface; this block only holds and
 * forwards their selects on o_cfg.
 */
module scr_regs
	import scr_pkg::*;
#(
	parameter int STEP_CYCLES      = SCR_STEP_CYCLES,
	parameter int STEP_SLOW_CYCLES = SCR_STEP_SLOW_CYCLES
) (
	input  wire logic     i_core_clk,
	input  wire logic     i_srst,
	input  wire scr_req_s i_req,
	input  wire logic [7:0] i_inactivity_count,
	input  wire logic [3:0] i_func_event,
	input  wire logic [3:0] i_func_irq,
	input  wire logic     i_irq_raw,
	output logic [7:0]    o_rdata,
	output logic          o_rvalid,
	output scr_cfg_s      o_cfg,
	output logic          o_comm_rst,
	output logic          o_irq_out,
	output logic          o_irq_oe
);

	logic [7:0]  rate_mode;
	logic [7:0]  power;
	logic [7:0]  wake_pin;
	logic        sleeping;
	logic [2:0]  boot_cnt;
	logic        booting;
	logic [31:0] step_cnt;
	logic [7:0]  steps;
	logic        wr_rate;
	logic        wr_power;
	logic        wr_wake;
	logic        soft_rst;
	logic        any_rst;
	logic [2:0]  next_rate;
	logic [1:0]  next_os;
	logic        wake_hit;
	logic [31:0] step_len;
	logic        timer_clr;
	logic        step_wrap;
	logic        irq_level;

	// oversampling ratio per scheme and rate code; a plain table, since the
	// high resolution column does not double evenly from row to row
	function automatic logic [10:0] os_ratio_of(input logic [1:0] os, input logic [2:0] dr);
		logic [10:0] r;
		r = 11'h002;
		unique case (scr_os_e'(os))
			SCR_OS_NORMAL: begin
				unique case (dr)
					SCR_DR_800:  r = 11'h002;
					SCR_DR_400,
					SCR_DR_200,
					SCR_DR_100,
					SCR_DR_50:   r = 11'h004;
					SCR_DR_12P5: r = 11'h010;
					SCR_DR_6P25: r = 11'h020;
					SCR_DR_1P56: r = 11'h080;
				endcase
			end
			SCR_OS_LNLP: begin
				unique case (dr)
					SCR_DR_800:  r = 11'h002;
					SCR_DR_400,
					SCR_DR_200,
					SCR_DR_100,
					SCR_DR_50,
					SCR_DR_12P5: r = 11'h004;
					SCR_DR_6P25: r = 11'h008;
					SCR_DR_1P56: r = 11'h020;
				endcase
			end
			SCR_OS_HIGH_RES: begin
				unique case (dr)
					SCR_DR_800:  r = 11'h002;
					SCR_DR_400:  r = 11'h004;
					SCR_DR_200:  r = 11'h008;
					SCR_DR_100:  r = 11'h010;
					SCR_DR_50:   r = 11'h020;
					SCR_DR_12P5: r = 11'h080;
					SCR_DR_6P25: r = 11'h100;
					SCR_DR_1P56: r = 11'h400;
				endcase
			end
			SCR_OS_LOW_POWER: begin
				unique case (dr)
					SCR_DR_800,
					SCR_DR_400,
					SCR_DR_200,
					SCR_DR_100,
					SCR_DR_50,
					SCR_DR_12P5: r = 11'h002;
					SCR_DR_6P25: r = 11'h004;
					SCR_DR_1P56: r = 11'h010;
				endcase
			end
		endcase
		return r;
	endfunction

	// one write strobe per register; a write to any other offset is dropped
	assign wr_rate  = i_req.wr && i_req.addr == SCR_OFS_RATE_MODE;
	assign wr_power = i_req.wr && i_req.addr == SCR_OFS_POWER;
	assign wr_wake  = i_req.wr && i_req.addr == SCR_OFS_WAKE_PIN;
	assign soft_rst = wr_power && i_req.wdata[SCR_B_SOFT_RST];
	assign any_rst  = i_srst || soft_rst;

	// boot sequence after a soft reset; writes are dropped while it runs,
	// so a host that keeps writing cannot undo the reload
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			boot_cnt <= 3'h0;
			booting  <= 1'b0;
		end else if (soft_rst) begin
			boot_cnt <= 3'(SCR_BOOT_CYCLES);
			booting  <= 1'b1;
		end else if (booting) begin
			boot_cnt <= boot_cnt - 3'h1;
			if (boot_cnt == 3'h1)
				booting <= 1'b0;
		end
	end

	// serial logic held in reset during boot
	always_ff @(posedge i_core_clk) begin
		if (i_srst)
			o_comm_rst <= 1'b0;
		else
			o_comm_rst <= soft_rst || (booting && boot_cnt != 3'h1);
	end

	// rate and mode register; while active only the mode bit moves, so the
	// sensing path never sees a low noise or fast read change mid-measurement, and sees a rate change only on sleep or wake
	always_ff @(posedge i_core_clk) begin
		if (any_rst) begin
			rate_mode <= SCR_RST_RATE_MODE;
		end else if (wr_rate && !booting) begin
			if (rate_mode[SCR_B_ACTIVE])
				rate_mode[SCR_B_ACTIVE] <= i_req.wdata[SCR_B_ACTIVE];
			else
				rate_mode <= i_req.wdata;
		end
	end

	// power scheme register
	always_ff @(posedge i_core_clk) begin
		if (any_rst)
			power <= SCR_RST_POWER;
		else if (wr_power && !booting)
			// reserved and reset bits never stored
			power <= i_req.wdata & SCR_MASK_POWER & ~(8'h01 << SCR_B_SOFT_RST);
	end

	// wake and pin register
	always_ff @(posedge i_core_clk) begin
		if (any_rst)
			wake_pin <= SCR_RST_WAKE_PIN;
		else if (wr_wake && !booting)
			wake_pin <= i_req.wdata & SCR_MASK_WAKE_PIN;
	end

	// read port; data follows the address every cycle and is taken the cycle
	// after the read strobe; the soft reset bit is never stored, so it reads zero
	always_ff @(posedge i_core_clk) begin
		if (any_rst) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			unique case (i_req.addr)
				SCR_OFS_RATE_MODE: o_rdata <= rate_mode;
				SCR_OFS_POWER:     o_rdata <= power;
				SCR_OFS_WAKE_PIN:  o_rdata <= wake_pin;
				default:           o_rdata <= 8'h00;
			endcase
		end
	end

	// a function with its wake-on bit clear still runs, it just cannot wake
	// only enabled functions wake; relies on host enabling irq
	assign wake_hit = |(i_func_irq & wake_pin[SCR_B_WAKE_LO +: 4]);
	// slowest rate uses the longer step
	assign step_len = (rate_mode[SCR_B_DR_LO +: 3] == SCR_DR_1P56) ?
		32'(STEP_SLOW_CYCLES) : 32'(STEP_CYCLES);
	// last cycle of one inactivity step
	assign step_wrap = step_cnt >= step_len - 32'h1;
	// auto-sleep enable gates the timer
	// standby or a cleared enable holds the timer at zero, so a later
	// enable always starts a full inactivity period
	assign timer_clr = any_rst || !rate_mode[SCR_B_ACTIVE] || !power[SCR_B_AUTO_SLEEP];

	// inactivity timer and sleep state; sleep is entered one cycle after
	// the last whole step ends
	always_ff @(posedge i_core_clk) begin
		if (timer_clr) begin
			sleeping <= 1'b0;
			step_cnt <= 32'h0;
			steps    <= 8'h00;
		end else if (sleeping) begin
			// wake wins; timer restarts from zero
			if (wake_hit) begin
				sleeping <= 1'b0;
				step_cnt <= 32'h0;
				steps    <= 8'h00;
			end
		end else if (|i_func_event) begin
			// any monitored event restarts the timer
			step_cnt <= 32'h0;
			steps    <= 8'h00;
		end else if (steps >= i_inactivity_count) begin
			sleeping <= 1'b1;
		end else if (step_wrap) begin
			step_cnt <= 32'h0;
			steps    <= steps + 8'h01;
		end else begin
			step_cnt <= step_cnt + 32'h1;
		end
	end

	// sleep codes 50, 12.5, 6.25, 1.56 Hz
	// data rate code used when awake
	assign next_rate = sleeping ? SCR_SLEEP_BASE + {1'b0, rate_mode[SCR_B_SLP_LO +: 2]}
		: rate_mode[SCR_B_DR_LO +: 3];
	// scheme per wake or sleep state
	assign next_os = sleeping ? power[SCR_B_SLEEP_OS_LO +: 2] : power[SCR_B_WAKE_OS_LO +: 2];

	// effective configuration to the sensing path
	// registered so that rate, scheme and ratio change with the sleep flag
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_cfg <= '0;
		end else begin
			o_cfg.active      <= rate_mode[SCR_B_ACTIVE];
			o_cfg.sleeping    <= sleeping;
			o_cfg.rate        <= next_rate;
			o_cfg.os_mode     <= next_os;
			o_cfg.os_ratio    <= os_ratio_of(next_os, next_rate);
			o_cfg.low_noise   <= rate_mode[SCR_B_LOW_NOISE];
			o_cfg.fast_read   <= rate_mode[SCR_B_FAST_READ];
			o_cfg.shift_check <= power[SCR_B_SHIFT_CHK];
		end
	end

	// asserted level follows the polarity select
	assign irq_level = wake_pin[SCR_B_POLARITY] ? i_irq_raw : !i_irq_raw;

	// interrupt pad: polarity and driver type; in open drain the pad only
	// drives while asserted and the shared line's pull sets the idle level
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_irq_out <= 1'b1;
			o_irq_oe  <= 1'b1;
		end else begin
			o_irq_out <= irq_level;
			// open drain drives only the asserted level
			o_irq_oe  <= !wake_pin[SCR_B_DRIVE] || i_irq_raw;
		end
	end

endmodule

// ==== logic/scr_pkg.sv ====
/*
 * Package for the system control register bank: offsets, field positions,
 * reset values, rate and oversampling encodings, timing constants.
 * Assumes a single 25 MHz core clock shared by every user of the package.
 */
package scr_pkg;

	// register offsets on the internal register port
	localparam logic [7:0] SCR_OFS_RATE_MODE = 8'h2A;
	localparam logic [7:0] SCR_OFS_POWER     = 8'h2B;
	localparam logic [7:0] SCR_OFS_WAKE_PIN  = 8'h2C;

	// reset values
	localparam logic [7:0] SCR_RST_RATE_MODE = 8'h00;
	localparam logic [7:0] SCR_RST_POWER     = 8'h00;
	localparam logic [7:0] SCR_RST_WAKE_PIN  = 8'h00;

	// writable bits; the rest read as zero
	localparam logic [7:0] SCR_MASK_POWER    = 8'hDF;
	localparam logic [7:0] SCR_MASK_WAKE_PIN = 8'h7B;

	// field positions in rate_and_mode_control
	localparam int SCR_B_ACTIVE     = 0;
	localparam int SCR_B_FAST_READ  = 1;
	localparam int SCR_B_LOW_NOISE  = 2;
	localparam int SCR_B_DR_LO      = 3;
	localparam int SCR_B_SLP_LO     = 6;
	// field positions in power_scheme_control
	localparam int SCR_B_WAKE_OS_LO = 0;
	localparam int SCR_B_AUTO_SLEEP = 2;
	localparam int SCR_B_SLEEP_OS_LO = 3;
	localparam int SCR_B_SOFT_RST   = 6;
	localparam int SCR_B_SHIFT_CHK  = 7;
	// field positions in wake_and_pin_control
	localparam int SCR_B_DRIVE      = 0;
	localparam int SCR_B_POLARITY   = 1;
	localparam int SCR_B_WAKE_LO    = 3;

	// data rate codes, 800 Hz down to 1.56 Hz
	localparam logic [2:0] SCR_DR_800  = 3'h0;
	localparam logic [2:0] SCR_DR_400  = 3'h1;
	localparam logic [2:0] SCR_DR_200  = 3'h2;
	localparam logic [2:0] SCR_DR_100  = 3'h3;
	localparam logic [2:0] SCR_DR_50   = 3'h4;
	localparam logic [2:0] SCR_DR_12P5 = 3'h5;
	localparam logic [2:0] SCR_DR_6P25 = 3'h6;
	localparam logic [2:0] SCR_DR_1P56 = 3'h7;
	// sleep codes map onto the four slowest rate codes, 4 to 7
	localparam logic [2:0] SCR_SLEEP_BASE = 3'h4;

	// oversampling schemes
	typedef enum logic [1:0] {
		SCR_OS_NORMAL    = 2'h0,
		SCR_OS_LNLP      = 2'h1,
		SCR_OS_HIGH_RES  = 2'h2,
		SCR_OS_LOW_POWER = 2'h3
	} scr_os_e;

	// core clock and inactivity step timing
	localparam int SCR_CLK_HZ          = 25_000_000;
	localparam int SCR_STEP_MS         = 320;
	localparam int SCR_STEP_SLOW_MS    = 640;
	localparam int SCR_STEP_CYCLES      = SCR_CLK_HZ / 1000 * SCR_STEP_MS;
	localparam int SCR_STEP_SLOW_CYCLES = SCR_CLK_HZ / 1000 * SCR_STEP_SLOW_MS;
	// boot length after a soft reset, in cycles
	localparam int SCR_BOOT_CYCLES     = 4;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scr_req_s;

	// effective operating configuration
	typedef struct packed {
		logic       active;
		logic       sleeping;
		logic [2:0] rate;
		logic [1:0] os_mode;
		logic [10:0] os_ratio;
		logic       low_noise;
		logic       fast_read;
		logic       shift_check;
	} scr_cfg_s;

endpackage

// ==== sim/scr_chk.sv ====
/* assertions on the ports of the control register bank
   assumes one core clock and the synchronous active-high reset */
module scr_chk
	import scr_pkg::*;
(
	input wire logic       i_core_clk,
	input wire logic       i_srst,
	input wire scr_req_s   i_req,
	input wire logic [7:0] i_inactivity_count,
	input wire logic [3:0] i_func_event,
	input wire logic [3:0] i_func_irq,
	input wire logic       i_irq_raw,
	input wire logic [7:0] o_rdata,
	input wire logic       o_rvalid,
	input wire scr_cfg_s   o_cfg,
	input wire logic       o_comm_rst,
	input wire logic       o_irq_out,
	input wire logic       o_irq_oe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	logic [7:0] last_addr;
	// address of the request that the read data answers
	always_ff @(posedge i_core_clk) begin
		last_addr <= i_req.addr;
	end
	rst_bit_zero_a: assert property (o_rvalid && last_addr == SCR_OFS_POWER
		|-> o_rdata[6:5] == 2'h0) else $error("power read shows reset or reserved bit");
	pin_resv_a: assert property (o_rvalid && last_addr == SCR_OFS_WAKE_PIN
		|-> !o_rdata[7] && !o_rdata[2]) else $error("wake pin reserved bit set");
	// awake rate only moves through standby
	rate_lock_a: assert property (o_cfg.active && $past(o_cfg.active) && !o_cfg.sleeping
		&& !$past(o_cfg.sleeping) |-> $stable(o_cfg.rate)) else $error("rate moved while active");
	sleep_rate_a: assert property (o_cfg.sleeping |-> o_cfg.rate >= SCR_SLEEP_BASE)
		else $error("sleep rate not in use");
	comm_len_a: assert property ($rose(o_comm_rst) |-> o_comm_rst[*4] ##1 !o_comm_rst)
		else $error("serial reset length wrong");
	soft_go_a: assert property (i_req.wr && i_req.addr == SCR_OFS_POWER
		&& i_req.wdata[6] && !o_comm_rst |-> ##[1:2] o_comm_rst) else $error("no soft reset");
	soft_clear_a: assert property ($fell(o_comm_rst) |-> !o_cfg.active && o_cfg.rate == 3'h0)
		else $error("config kept over soft reset");
	os_fast_a: assert property (o_cfg.active && o_cfg.rate == SCR_DR_800
		|-> o_cfg.os_ratio == 11'h002) else $error("ratio at fastest rate");
	os_hires_a: assert property (o_cfg.active && o_cfg.rate == SCR_DR_1P56
		&& o_cfg.os_mode == SCR_OS_HIGH_RES |-> o_cfg.os_ratio == 11'h400) else $error("hires ratio");
	cover property (o_cfg.sleeping);
	cover property ($rose(o_comm_rst));
	cover property (!o_irq_oe);
endmodule

bind scr_regs scr_chk u_chk (.i_core_clk, .i_srst, .i_req, .i_inactivity_count, .i_func_event,
	.i_func_irq, .i_irq_raw, .o_rdata, .o_rvalid, .o_cfg, .o_comm_rst, .o_irq_out, .o_irq_oe);

// ==== sim/scr_host.sv ====
/* host model: single-byte register cycles on the strobe port
   assumes the caller runs its tasks from one process */
module scr_host
	import scr_pkg::*;
(
	input wire logic i_core_clk,
	output scr_req_s o_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_req = '0;
	// one strobe cycle; a gap edge before the next keeps strobes pulses
	task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_req <= {w, !w, a, d};
		@(posedge i_core_clk);
		o_req <= '0;
	endtask
endmodule

// ==== sim/testbench.sv ====
/* bench for the control register bank: access, rates, sleep, pad, soft reset
   assumes the host model drives the strobe port */
module testbench;
	import scr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, srst = 1, raw = 0, rvalid, crst, iout, ioe;
	logic [7:0] cnt = 8'h02, rdata, v;
	logic [3:0] ev = 4'h0, fi = 4'h0;
	scr_req_s   req;
	scr_cfg_s   cfg;
	int         fail_count = 0, checks = 0, seed = 97276;
	// 25 MHz core clock
	always #20 clk = ~clk;
	scr_host u_scr_host (.i_core_clk(clk), .o_req(req));
	scr_regs #(.STEP_CYCLES(4), .STEP_SLOW_CYCLES(8)) u_scr_regs (.i_core_clk(clk),
		.i_srst(srst), .i_req(req), .i_inactivity_count(cnt), .i_func_event(ev),
		.i_func_irq(fi), .i_irq_raw(raw), .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg),
		.o_comm_rst(crst), .o_irq_out(iout), .o_irq_oe(ioe));
	// oversampling ratio per scheme; each row runs from the slowest rate up
	function automatic logic [10:0] osr(input logic [1:0] m, input logic [2:0] c);
		logic [87:0] row;
		case (m)
			2'h0: row = {11'h080, 11'h020, 11'h010, 11'h004, 11'h004, 11'h004, 11'h004, 11'h002};
			2'h1: row = {11'h020, 11'h008, 11'h004, 11'h004, 11'h004, 11'h004, 11'h004, 11'h002};
			2'h2: row = {11'h400, 11'h100, 11'h080, 11'h020, 11'h010, 11'h008, 11'h004, 11'h002};
			default: row = {11'h010, 11'h004, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002};
		endcase
		return row[c * 11 +: 11];
	endfunction
	function automatic logic [10:0] pad(input logic p, input logic d, input logic r);
		return d ? {9'h0, r, r & p} : {9'h0, 1'b1, r ~^ p};
	endfunction
	task automatic cmp(input string n, input logic [10:0] e, input logic [10:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		u_scr_host.cyc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		u_scr_host.cyc(1'b0, a, 8'h00);
		#1 cmp(n, {3'h1, e}, {2'h0, rvalid, rdata});
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// bounded wait for the sleep state, then compare it
	task automatic hold(input logic want);
		for (int k = 0; k < 40 && cfg.sleeping !== want; k++) @(posedge clk) #1;
		cmp("sleeping", want, cfg.sleeping);
	endtask
	task automatic close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(SCR_OFS_RATE_MODE, SCR_RST_RATE_MODE, "rate_mode");
		rd(SCR_OFS_POWER, SCR_RST_POWER, "power");
		rd(SCR_OFS_WAKE_PIN, SCR_RST_WAKE_PIN, "wake_pin");
		rd(8'h2D, 8'h00, "unmapped");
		repeat (6) begin
			v = $random(seed);
			w(SCR_OFS_POWER, v & 8'hBF);
			rd(SCR_OFS_POWER, v & 8'hBF & SCR_MASK_POWER, "power");
			w(SCR_OFS_WAKE_PIN, v);
			rd(SCR_OFS_WAKE_PIN, v & SCR_MASK_WAKE_PIN, "wake_pin");
			w(SCR_OFS_RATE_MODE, v & 8'hFE);
			rd(SCR_OFS_RATE_MODE, v & 8'hFE, "rate_mode");
		end
		v = $random(seed);
		w(SCR_OFS_POWER, 8'h80);
		w(SCR_OFS_RATE_MODE, v | 8'h01);
		settle;
		cmp("rate", {8'h0, v[5:3]}, cfg.rate);
		cmp("flags", {v[2:1], 2'h3}, {cfg.low_noise, cfg.fast_read, cfg.shift_check, cfg.active});
		repeat (12) @(posedge clk);
		#1 cmp("auto_off", 11'h0, cfg.sleeping);
		w(SCR_OFS_RATE_MODE, ~v);
		rd(SCR_OFS_RATE_MODE, {v[7:1], ~v[0]}, "locked");
		for (int m = 0; m < 4; m++) begin
			w(SCR_OFS_POWER, 8'(m));
			for (int c = 0; c < 8; c++) begin
				w(SCR_OFS_RATE_MODE, 8'h00);
				w(SCR_OFS_RATE_MODE, 8'(c << 3) | 8'h01);
				settle;
				cmp("os_ratio", osr(2'(m), 3'(c)), cfg.os_ratio);
				cmp("os_mode", 11'(m), cfg.os_mode);
			end
		end
		for (int s = 0; s < 4; s++) begin
			w(SCR_OFS_RATE_MODE, 8'h00);
			w(SCR_OFS_POWER, 8'h1C);
			w(SCR_OFS_WAKE_PIN, 8'h08 << s);
			w(SCR_OFS_RATE_MODE, 8'(s << 6) | 8'h01);
			repeat (12) @(posedge clk) ev <= 4'($random(seed)) | 4'h1;
			@(posedge clk) ev <= 4'h0;
			#1 cmp("restarted", 11'h0, cfg.sleeping);
			hold(1'b1);
			cmp("sleep_rate", 11'(SCR_SLEEP_BASE + 3'(s)), cfg.rate);
			cmp("sleep_os", 11'(SCR_OS_LOW_POWER), cfg.os_mode);
			@(posedge clk) fi <= 4'(1 << ((s + 1) % 4));
			@(posedge clk) fi <= 4'h0;
			repeat (3) @(posedge clk);
			#1 cmp("bypassed", 11'h1, cfg.sleeping);
			@(posedge clk) fi <= 4'(1 << s);
			@(posedge clk) fi <= 4'h0;
			hold(1'b0);
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge clk) raw <= k[2];
			w(SCR_OFS_WAKE_PIN, 8'(k[1:0]));
			settle;
			cmp("pad", pad(k[1], k[0], k[2]), {9'h0, ioe, ioe & iout});
		end
		w(SCR_OFS_POWER, 8'hC0);
		@(posedge clk);
		#1 cmp("comm_rst", 11'h1, crst);
		repeat (8) @(posedge clk);
		#1 cmp("active", 11'h0, cfg.active);
		rd(SCR_OFS_RATE_MODE, 8'h00, "rate_mode");
		rd(SCR_OFS_POWER, 8'h00, "power");
		rd(SCR_OFS_WAKE_PIN, 8'h00, "wake_pin");
		close_out;
	end
	// watchdog well past the expected run length
	initial begin
		#200000;
		fail_count++;
		close_out;
	end
endmodule
